// *** common/atb_defines.svh ***
// Constants for the advanced timer time-base unit: offsets, fields, resets.
// Assumes a 32-bit AHB-Lite slave port and one 125 MHz clock.
//
// Functional notes
// - Prescaler divides by 1 to 65536, 16-bit
// - New prescale ratio applies at next refresh
// - Software sees reload preload, not the shadow
// - Reload shadow follows preload unless buffering enabled
// - Counter advances only on gated prescaler tick
// - Counting starts one cycle after enable write
// - Upcount 0 to limit, wrap, signal overflow
// - Refresh after repeat setting plus one overflows
// - Refresh generate gives immediate refresh event
// - Refresh inhibit blocks events and buffered shadow loads; repetition counter still reloads
// - Forced reinit clears counter and prescaler always
// - Source select hides flag for forced refresh
// - Refresh reloads repeat, reload, prescale; sets flag
// - Overflow issues refresh only while not inhibited
// - Count, limit, prescale accessible any time
// - Refresh events raise interrupt or DMA request
`ifndef ATB_DEFINES_SVH
`define ATB_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ATB_OFF_CONTROL_ONE 8'h00
`define ATB_OFF_INT_MASK 8'h04
`define ATB_OFF_STATUS_REG 8'h08
`define ATB_OFF_EVENT_GENERATE 8'h0c
`define ATB_OFF_COUNT_VALUE 8'h10
`define ATB_OFF_PRESCALE 8'h14
`define ATB_OFF_RELOAD_LIMIT 8'h18
`define ATB_OFF_REPEAT_COUNT 8'h1c

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ATB_BIT_COUNT_ENABLE 0
`define ATB_BIT_REFRESH_INHIBIT 1
`define ATB_BIT_SOURCE_SELECT 2
`define ATB_BIT_DMA_ENABLE 3
`define ATB_BIT_RELOAD_BUFFER 7
`define ATB_BIT_REFRESH_FLAG 0
`define ATB_BIT_OVERFLOW_FLAG 1
`define ATB_BIT_REFRESH_GENERATE 0

// ------------------------------------------------------------
// Widths and reset values
// ------------------------------------------------------------
`define ATB_CNT_WIDTH 32
`define ATB_PSC_WIDTH 16
`define ATB_REP_WIDTH 8
`define ATB_NUM_FLAGS 2
`define ATB_RST_PRESCALE 16'h0000
`define ATB_RST_REPEAT 8'h00
`define ATB_RST_MASK 2'h0

`endif

// *** common/atb_pkg.sv ***
// Types shared by the time-base unit.
// Assumes atb_defines.svh is on the include path.
`include "atb_defines.svh"
`default_nettype none

package atb_pkg;
    typedef struct packed {
        logic reload_buffer_enable;
        logic dma_enable;
        logic refresh_source_select;
        logic refresh_inhibit;
        logic count_enable_bit;
    } atb_ctrl_t;

    typedef logic [`ATB_NUM_FLAGS-1:0] atb_flags_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] offset;
    } atb_access_t;
endpackage

`default_nettype wire

// *** verilog/atb_time_base.sv ***
// Time-base unit: prescaler, up counter, buffered reload, repetition counter.
// Assumes a single AHB-Lite master, word accesses only, one clock hclk.
`include "atb_defines.svh"
`default_nettype none

module atb_time_base
    import atb_pkg::*;
#(
    parameter int CW = `ATB_CNT_WIDTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic slave_refresh_trigger,
    output logic refresh_pulse,
    output logic irq,
    output logic dma_req
);

    // ------------------------------------------------------------
    // Decode helper
    // ------------------------------------------------------------
    function automatic logic hit(input atb_access_t a, input logic [7:0] off);
        hit = a.valid && (a.offset == off);
    endfunction

    // ------------------------------------------------------------
    // Bus slave: address phase capture
    // ------------------------------------------------------------
    atb_access_t acc_q;
    atb_access_t acc_d;
    logic [31:0] rdata_d;
    logic rd_now;

    always_comb begin
        acc_d.valid = hsel && htrans[1] && hready;
        acc_d.write = hwrite;
        acc_d.offset = {haddr[7:2], 2'b00};
    end

    assign rd_now = acc_d.valid && !acc_d.write;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Zero wait states, so hreadyout only leaves reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Data-phase write strobes
    logic wr_ctrl;
    logic wr_mask;
    logic wr_egr;
    logic wr_cnt;
    logic wr_psc;
    logic wr_arr;
    logic wr_rep;

    assign wr_ctrl = acc_q.write && hit(acc_q, `ATB_OFF_CONTROL_ONE);
    assign wr_mask = acc_q.write && hit(acc_q, `ATB_OFF_INT_MASK);
    assign wr_egr = acc_q.write && hit(acc_q, `ATB_OFF_EVENT_GENERATE);
    assign wr_cnt = acc_q.write && hit(acc_q, `ATB_OFF_COUNT_VALUE);
    assign wr_psc = acc_q.write && hit(acc_q, `ATB_OFF_PRESCALE);
    assign wr_arr = acc_q.write && hit(acc_q, `ATB_OFF_RELOAD_LIMIT);
    assign wr_rep = acc_q.write && hit(acc_q, `ATB_OFF_REPEAT_COUNT);

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    atb_ctrl_t control_one_q;
    atb_flags_t int_mask_q;
    logic [`ATB_PSC_WIDTH-1:0] prescale_setting_q;
    logic [CW-1:0] reload_limit_q;
    logic [`ATB_REP_WIDTH-1:0] repeat_count_setting_q;

    // enable registered
    // Enable lands on the edge that ends the write's data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_one_q <= '0;
        end else if (wr_ctrl) begin
            control_one_q.count_enable_bit <= hwdata[`ATB_BIT_COUNT_ENABLE];
            control_one_q.refresh_inhibit <= hwdata[`ATB_BIT_REFRESH_INHIBIT];
            control_one_q.refresh_source_select <= hwdata[`ATB_BIT_SOURCE_SELECT];
            control_one_q.dma_enable <= hwdata[`ATB_BIT_DMA_ENABLE];
            control_one_q.reload_buffer_enable <= hwdata[`ATB_BIT_RELOAD_BUFFER];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_mask_q <= `ATB_RST_MASK;
        end else if (wr_mask) begin
            int_mask_q <= hwdata[`ATB_NUM_FLAGS-1:0];
        end
    end

    // written while running
    // Preload copies only; the counter never sees these directly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale_setting_q <= `ATB_RST_PRESCALE;
        end else if (wr_psc) begin
            prescale_setting_q <= hwdata[`ATB_PSC_WIDTH-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_limit_q <= '1;
        end else if (wr_arr) begin
            reload_limit_q <= hwdata[CW-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            repeat_count_setting_q <= `ATB_RST_REPEAT;
        end else if (wr_rep) begin
            repeat_count_setting_q <= hwdata[`ATB_REP_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    logic [`ATB_PSC_WIDTH-1:0] psc_cnt_q;
    logic [`ATB_PSC_WIDTH-1:0] psc_buf_q;
    logic [CW-1:0] count_value_q;
    logic [CW-1:0] reload_shadow_q;
    logic [`ATB_REP_WIDTH-1:0] rep_cnt_q;
    logic counter_tick;
    logic overflow;
    logic rep_done;
    logic force_refresh;
    logic refresh_event;
    logic flag_set;

    assign counter_tick = control_one_q.count_enable_bit && (psc_cnt_q == psc_buf_q);
    assign overflow = counter_tick && (count_value_q == reload_shadow_q);
    assign rep_done = overflow && (rep_cnt_q == '0);
    assign force_refresh = (wr_egr && hwdata[`ATB_BIT_REFRESH_GENERATE]) ||
                           slave_refresh_trigger;
    assign refresh_event = !control_one_q.refresh_inhibit && (rep_done || force_refresh);
    // forced refresh silent when source select set
    // A repetition-end overflow (rep_done) in the same cycle still reports, it is a genuine source
    assign flag_set = refresh_event &&
                      (rep_done || !control_one_q.refresh_source_select);

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    // 16-bit compare divider
    // Compare on equality, so a setting of N divides by N+1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psc_cnt_q <= '0;
        end else if (force_refresh) begin
            psc_cnt_q <= '0;
        end else if (control_one_q.count_enable_bit) begin
            if (psc_cnt_q == psc_buf_q) begin
                psc_cnt_q <= '0;
            end else begin
                psc_cnt_q <= psc_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psc_buf_q <= `ATB_RST_PRESCALE;
        end else if (refresh_event) begin
            psc_buf_q <= prescale_setting_q;
        end
    end

    // ------------------------------------------------------------
    // Main counter
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value_q <= '0;
        end else if (force_refresh) begin
            count_value_q <= '0;
        end else if (wr_cnt) begin
            count_value_q <= hwdata[CW-1:0];
        end else if (overflow) begin
            count_value_q <= '0;
        end else if (counter_tick) begin
            count_value_q <= count_value_q + 1'b1;
        end
    end

    // shadow transfer
    // Unbuffered mode follows the preload every cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_shadow_q <= '1;
        end else if (!control_one_q.reload_buffer_enable || refresh_event) begin
            reload_shadow_q <= reload_limit_q;
        end
    end

    // ------------------------------------------------------------
    // Repetition counter
    // ------------------------------------------------------------
    // Auto-reloads when spent, even if inhibited, to keep the rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rep_cnt_q <= `ATB_RST_REPEAT;
        end else if (refresh_event || rep_done) begin
            rep_cnt_q <= repeat_count_setting_q;
        end else if (overflow) begin
            rep_cnt_q <= rep_cnt_q - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Status, mask and interrupt
    // ------------------------------------------------------------
    atb_flags_t status_q;
    atb_flags_t status_d;
    atb_flags_t status_set;
    logic status_rd;

    assign status_set[`ATB_BIT_REFRESH_FLAG] = flag_set;
    assign status_set[`ATB_BIT_OVERFLOW_FLAG] = overflow;
    assign status_rd = rd_now && hit(acc_d, `ATB_OFF_STATUS_REG);

    // Set wins over the read-clear so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < `ATB_NUM_FLAGS; gi++) begin : g_flag
            assign status_d[gi] = status_set[gi] || (status_q[gi] && !status_rd);
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    // interrupt and DMA
    // irq built from the next status, so a read-clear drops it at once; dma_req from flag_set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_d & int_mask_q);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_req <= 1'b0;
        end else begin
            dma_req <= flag_set && control_one_q.dma_enable;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refresh_pulse <= 1'b0;
        end else begin
            refresh_pulse <= refresh_event;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = '0;
        case (acc_d.offset)
            `ATB_OFF_CONTROL_ONE: begin
                rdata_d[`ATB_BIT_COUNT_ENABLE] = control_one_q.count_enable_bit;
                rdata_d[`ATB_BIT_REFRESH_INHIBIT] = control_one_q.refresh_inhibit;
                rdata_d[`ATB_BIT_SOURCE_SELECT] = control_one_q.refresh_source_select;
                rdata_d[`ATB_BIT_DMA_ENABLE] = control_one_q.dma_enable;
                rdata_d[`ATB_BIT_RELOAD_BUFFER] = control_one_q.reload_buffer_enable;
            end
            `ATB_OFF_INT_MASK: rdata_d[`ATB_NUM_FLAGS-1:0] = int_mask_q;
            `ATB_OFF_STATUS_REG: rdata_d[`ATB_NUM_FLAGS-1:0] = status_q;
            `ATB_OFF_COUNT_VALUE: rdata_d[CW-1:0] = count_value_q;
            `ATB_OFF_PRESCALE: rdata_d[`ATB_PSC_WIDTH-1:0] = prescale_setting_q;
            `ATB_OFF_RELOAD_LIMIT: rdata_d[CW-1:0] = reload_limit_q;
            `ATB_OFF_REPEAT_COUNT: rdata_d[`ATB_REP_WIDTH-1:0] = repeat_count_setting_q;
            default: rdata_d = '0;
        endcase
    end

    // Sampled in the address phase, held through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_now) begin
            hrdata <= rdata_d;
        end
    end

endmodule

`default_nettype wire

// *** test/atb_time_base_monitor.sv ***
// Checker for the time-base unit, bound to its top module.
// Assumes word accesses; mirrors control and mask from bus writes.
`default_nettype none

module atb_time_base_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic slave_refresh_trigger,
    input wire logic refresh_pulse,
    input wire logic irq,
    input wire logic dma_req
);
    logic ap_q, wr_q;
    logic [5:0] off_q;
    logic [7:0] ctrl_q;
    logic [1:0] mask_q;
    wire ap = hsel && htrans[1] && hready;

    // ------------------------------------------------------------
    // Bus mirror
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= 1'b0;
            wr_q <= 1'b0;
            off_q <= 6'h00;
        end else if (hready) begin
            ap_q <= ap;
            wr_q <= hwrite;
            off_q <= haddr[7:2];
        end
    end
    // Lands on the data-phase edge, as the register does
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= 8'h00;
            mask_q <= 2'h0;
        end else if (ap_q && wr_q && hready) begin
            if (off_q == 6'h00) ctrl_q <= hwdata[7:0] & 8'h8f;
            if (off_q == 6'h01) mask_q <= hwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    bus_ready_a: assert property (hreadyout)
        else $error("hreadyout dropped");
    bus_okay_a: assert property (!hresp)
        else $error("error response seen");
    unmapped_zero_a: assert property (ap && !hwrite && (haddr[7:2] > 6'h07 ||
        haddr[7:2] == 6'h03) |=> hrdata == 32'h0) else $error("unmapped read not zero");
    ctrl_readback_a: assert property (ap && !hwrite && haddr[7:2] == 6'h00
        |=> hrdata[7:0] == $past(ctrl_q)) else $error("control readback wrong");
    forced_refresh_a: assert property (slave_refresh_trigger && !ctrl_q[1]
        |=> refresh_pulse) else $error("forced refresh lost");
    inhibit_silent_a: assert property (ctrl_q[1] |=> !refresh_pulse)
        else $error("refresh while inhibited");
    mask_quiet_a: assert property (mask_q == 2'h0 ##1 mask_q == 2'h0 |-> !irq)
        else $error("irq with mask clear");
    dma_paired_a: assert property (dma_req |-> refresh_pulse)
        else $error("dma request without refresh");
    silent_force_a: assert property (slave_refresh_trigger && ctrl_q[2:0] == 3'b100
        |=> refresh_pulse && !dma_req) else $error("flag set by forced refresh");
endmodule

bind atb_time_base atb_time_base_monitor mon_u (.*);

`default_nettype wire

// *** test/test_atb_time_base.sv ***
// Self-checking bench for the time-base unit over its bus port.
// Assumes zero wait states; period is measured between refresh pulses.
`default_nettype none

module test_atb_time_base;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, trig, pulse, irq, dma;
    logic [1:0] htrans;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int err_count = 0, checks = 0, seed = 32'h32ac, cyc = 0, np = 0, nd = 0;
    int t0, t1, t2, p, l, r, n, d;

    atb_time_base dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .slave_refresh_trigger(trig), .refresh_pulse(pulse), .irq(irq), .dma_req(dma));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (pulse) np <= np + 1;
        if (dma) nd <= nd + 1;
    end

    // ------------------------------------------------------------
    // Bus, compare and timing helpers
    // ------------------------------------------------------------
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task automatic wp(output int t);
        @(posedge hclk);
        while (!pulse) @(posedge hclk);
        t = cyc;
    endtask
    // Stop, program, force a refresh so buffers load, then start
    task automatic setup(input int sp, input int sl, input int sr, input logic [7:0] c);
        bus(8'h00, 1'b1, 32'h0);
        bus(8'h14, 1'b1, 32'(sp));
        bus(8'h18, 1'b1, 32'(sl));
        bus(8'h1c, 1'b1, 32'(sr));
        bus(8'h0c, 1'b1, 32'h1);
        bus(8'h00, 1'b1, {24'h0, c});
    endtask
    function automatic int per(input int fp, input int fl, input int fr);
        return (fp + 1) * (fl + 1) * (fr + 1);
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Generous bound: the whole run needs only a few hundred cycles
    initial begin
        #400000;
        err_count++;
        tally_and_finish;
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        trig = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 9; i++) rdchk(8'(4 * i), (i == 6) ? 32'hffffffff : 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            p = (i == 0) ? 0 : $unsigned($random(seed)) % 3;
            l = (i == 0) ? 0 : 1 + $unsigned($random(seed)) % 4;
            r = (i == 0) ? 0 : $unsigned($random(seed)) % 3;
            setup(p, l, r, 8'h01);
            wp(t0);
            wp(t1);
            chk("period", 32'(per(p, l, r)), 32'(t1 - t0));
        end
        $display("test periods done");
        setup(1, 5, 0, 8'h81);
        wp(t0);
        bus(8'h14, 1'b1, 32'h0);
        bus(8'h18, 1'b1, 32'h2);
        wp(t1);
        wp(t2);
        chk("old period", 32'(per(1, 5, 0)), 32'(t1 - t0));
        chk("new period", 32'(per(0, 2, 0)), 32'(t2 - t1));
        $display("test buffered change done");
        bus(8'h00, 1'b1, 32'h3);
        // A pulse launched before inhibit lands is still in flight
        repeat (2) @(posedge hclk);
        n = np;
        repeat (40) @(posedge hclk);
        bus(8'h00, 1'b1, 32'h2);
        bus(8'h14, 1'b1, 32'h3);
        bus(8'h10, 1'b1, 32'h5);
        rdchk(8'h10, 32'h5);
        bus(8'h0c, 1'b1, 32'h1);
        trig <= 1'b1;
        @(posedge hclk);
        trig <= 1'b0;
        rdchk(8'h10, 32'h0);
        rdchk(8'h14, 32'h3);
        chk("pulses inhibited", 32'(n), 32'(np));
        $display("test inhibit done");
        bus(8'h00, 1'b1, 32'hc);
        bus(8'h04, 1'b1, 32'h1);
        bus(8'h08, 1'b0, 32'h0);
        n = np;
        d = nd;
        trig <= 1'b1;
        @(posedge hclk);
        trig <= 1'b0;
        bus(8'h0c, 1'b1, 32'h1);
        repeat (2) @(posedge hclk);
        chk("forced pulses", 32'(n + 2), 32'(np));
        chk("silent dma", 32'(d), 32'(nd));
        chk("silent irq", 32'h0, {31'h0, irq});
        bus(8'h00, 1'b1, 32'h8);
        bus(8'h0c, 1'b1, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        chk("dma sent", 32'(d + 1), 32'(nd));
        rdchk(8'h08, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus(8'h04, 1'b1, 32'h0);
        bus(8'h0c, 1'b1, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdchk(8'h08, 32'h1);
        $display("test flags done");
        tally_and_finish;
    end
endmodule

`default_nettype wire
